// ### design/nmic_ctrl.sv
// interrupt controller: non-maskable path, maskable arbiter, entry and return
//
// Local design decision: the Avalon-MM slave port.
`timescale 1ns/1ns
module nmic_ctrl
  import nmic_pkg::*;
#(
  parameter int unsigned NSRC = NMIC_NSRC  // number of maskable sources
)(
  input  wire logic                   clk,               // system clock
  input  wire logic                   nrst,              // sync reset, active low
  input  wire logic [NMIC_ADDR_W-1:0] avs_address,       // byte address
  input  wire logic                   avs_read,          // read request
  input  wire logic                   avs_write,         // write request
  input  wire logic [31:0]            avs_writedata,     // write data
  output logic      [31:0]            avs_readdata,      // read data
  output logic                        avs_waitrequest,   // stall
  input  wire logic                   nmi_pin,           // non-maskable pin, async
  input  wire logic [NSRC-1:0]        irq_req,           // request pulses, same clock
  input  wire logic [31:0]            ret_pc,            // return pc offered by core
  input  wire logic                   return_from_interrupt_req,          // return_from_interrupt pulse
  input  wire logic                   ei_req,            // unmask_all_instr pulse
  input  wire logic                   di_req,            // mask_all_instr pulse
  input  wire logic                   sys_wr,            // load_system_reg_instr pulse
  input  wire nmic_pkg::nmic_sysreg_t sys_sel,           // system register selected
  input  wire logic [31:0]            sys_wdata,         // value loaded
  output logic      [31:0]            psw_q,             // program_status_word
  output logic      [31:0]            nmi_saved_pc_q,    // nmi_saved_pc
  output logic      [31:0]            nmi_saved_st_q,    // nmi_saved_status
  output logic      [31:0]            mi_saved_pc_q,     // maskable_saved_pc
  output logic      [31:0]            mi_saved_st_q,     // maskable_saved_status
  output logic      [31:0]            ecr_q,             // exception_cause_reg
  output logic      [7:0]             isr_q,             // in_service_levels_reg
  output logic                        pc_load_q,         // one-cycle pc redirect
  output logic      [31:0]            pc_addr_q          // redirect target
);
  // refused at elaboration; the source index below is six bits wide
  if (NSRC < 1 || NSRC > NMIC_NSRC) begin : g_nsrc_check
    $error("nmic_ctrl: NSRC out of range");
  end

  localparam int unsigned IDX_W = 6;

  // handler vector and cause code from source index
  function automatic logic [15:0] mi_code(input logic [IDX_W-1:0] idx);
    mi_code = NMIC_MI_CODE_0 + {6'h00, idx, 4'h0};
  endfunction : mi_code

  // ---------------- bus slave ----------------
  logic        bus_req;
  logic        wr_commit;
  logic [7:0]  edge_cfg_q;
  logic [NSRC-1:0] pend;
  logic [NSRC-1:0] mask;
  logic [2:0]      prio [NSRC];
  logic [31:0] rd_d;

  assign bus_req   = avs_read | avs_write;
  // one wait cycle, then the answer; write lands on the released edge
  assign wr_commit = avs_write & ~avs_waitrequest;

  always_ff @(posedge clk) begin
    if (!nrst) begin
      avs_waitrequest <= 1'b1;
    end else begin
      avs_waitrequest <= ~(bus_req & avs_waitrequest);
    end
  end

  // unmapped addresses read as zero
  always_comb begin
    rd_d = 32'h0000_0000;
    if (avs_address == NMIC_EDGE_ADDR) begin
      rd_d = {24'h000000, edge_cfg_q};
    end else if (avs_address == NMIC_ISR_ADDR) begin
      rd_d = {24'h000000, isr_q};
    end else begin
      for (int i = 0; i < NSRC; i++) begin
        if (avs_address == NMIC_CTRL_BASE + 28'(4 * i)) begin
          rd_d = {24'h000000, pend[i], mask[i], 3'b000, prio[i]};
        end
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      avs_readdata <= 32'h0000_0000;
    end else if (avs_read & avs_waitrequest) begin
      avs_readdata <= rd_d;
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      edge_cfg_q <= NMIC_EDGE_RESET;
    end else if (wr_commit && avs_address == NMIC_EDGE_ADDR) begin
      // only the select bit is writable, the rest read zero
      edge_cfg_q <= {7'h00, avs_writedata[NMIC_EDGE_SEL_B]};
    end
  end

  // ---------------- non-maskable pin ----------------
  logic nmi_s1_q;
  logic nmi_s2_q;
  logic nmi_s3_q;
  logic nmi_edge;
  logic nmi_pend_q;

  // two stages for the pin; the third only feeds the edge compare
  always_ff @(posedge clk) begin
    if (!nrst) begin
      nmi_s1_q <= 1'b0;
      nmi_s2_q <= 1'b0;
      nmi_s3_q <= 1'b0;
    end else begin
      nmi_s1_q <= nmi_pin;
      nmi_s2_q <= nmi_s1_q;
      nmi_s3_q <= nmi_s2_q;
    end
  end

  assign nmi_edge = edge_cfg_q[NMIC_EDGE_SEL_B] ? (nmi_s2_q & ~nmi_s3_q)
                                                : (~nmi_s2_q & nmi_s3_q);

  // ---------------- acceptance ----------------
  logic             np;
  logic             ep;
  logic             id;
  logic             cpu_evt;
  logic             take_nmi;
  logic             take_mi;
  logic             best_found;
  logic [IDX_W-1:0] best_idx;
  logic [2:0]       best_lvl;
  logic             isr_any;
  logic [2:0]       isr_top;
  logic [NSRC-1:0]  ack;

  assign np = psw_q[NMIC_PSW_NP_B];
  assign ep = psw_q[NMIC_PSW_EP_B];
  assign id = psw_q[NMIC_PSW_ID_B];
  // core events take the cycle; acceptance waits one
  assign cpu_evt = return_from_interrupt_req | ei_req | di_req | sys_wr;

  always_comb begin
    best_found = 1'b0;
    best_idx   = '0;
    best_lvl   = 3'h7;
    // ascending scan with strict compare keeps the lowest index on ties
    for (int i = 0; i < NSRC; i++) begin
      if (pend[i] && !mask[i] && (!best_found || prio[i] < best_lvl)) begin
        best_found = 1'b1;
        best_idx   = IDX_W'(i);
        best_lvl   = prio[i];
      end
    end
  end

  // lowest set bit is the level now in service
  always_comb begin
    isr_any = 1'b0;
    isr_top = 3'h7;
    for (int l = 7; l >= 0; l--) begin
      if (isr_q[l]) begin
        isr_any = 1'b1;
        isr_top = 3'(l);
      end
    end
  end

  assign take_nmi = nmi_pend_q & ~np & ~cpu_evt;
  assign take_mi  = best_found & (~isr_any | (best_lvl < isr_top))
                  & ~np & ~id & ~take_nmi & ~cpu_evt;

  // only the winner loses its pending flag
  always_comb begin
    ack = '0;
    if (take_mi) begin
      ack[best_idx] = 1'b1;
    end
  end

  // repeated edges while one waits collapse into this single flag
  always_ff @(posedge clk) begin
    if (!nrst) begin
      nmi_pend_q <= 1'b0;
    end else if (nmi_edge) begin
      nmi_pend_q <= 1'b1;
    end else if (take_nmi) begin
      nmi_pend_q <= 1'b0;
    end
  end

  // ---------------- maskable sources ----------------
  genvar g;
  generate
    for (g = 0; g < NSRC; g++) begin : g_src
      nmic_src u_src (
        .clk    (clk),
        .nrst   (nrst),
        .req    (irq_req[g]),
        .ack    (ack[g]),
        .wr     (wr_commit && avs_address == NMIC_CTRL_BASE + 28'(4 * g)),
        .wdata  (avs_writedata[7:0]),
        .pend_q (pend[g]),
        .mask_q (mask[g]),
        .prio_q (prio[g])
      );
    end
  endgenerate

  // ---------------- status word ----------------
  always_ff @(posedge clk) begin
    if (!nrst) begin
      psw_q <= NMIC_PSW_RESET;
    end else if (take_nmi) begin
      psw_q[NMIC_PSW_NP_B] <= 1'b1;
      psw_q[NMIC_PSW_ID_B] <= 1'b1;
      psw_q[NMIC_PSW_EP_B] <= 1'b0;
    end else if (take_mi) begin
      psw_q[NMIC_PSW_ID_B] <= 1'b1;
      psw_q[NMIC_PSW_EP_B] <= 1'b0;
    end else if (return_from_interrupt_req && !ep) begin
      psw_q <= np ? nmi_saved_st_q : mi_saved_st_q;
    end else if (sys_wr && sys_sel == NMIC_SR_PSW) begin
      psw_q <= sys_wdata;
    end else if (ei_req) begin
      psw_q[NMIC_PSW_ID_B] <= 1'b0;
    end else if (di_req) begin
      psw_q[NMIC_PSW_ID_B] <= 1'b1;
    end
  end

  // ---------------- saved copies and cause ----------------
  always_ff @(posedge clk) begin
    if (!nrst) begin
      nmi_saved_pc_q <= 32'h0000_0000;
      nmi_saved_st_q <= 32'h0000_0000;
    end else if (take_nmi) begin
      nmi_saved_pc_q <= ret_pc;
      nmi_saved_st_q <= psw_q;
    end else if (sys_wr && sys_sel == NMIC_SR_NMI_PC) begin
      nmi_saved_pc_q <= sys_wdata;
    end else if (sys_wr && sys_sel == NMIC_SR_NMI_ST) begin
      nmi_saved_st_q <= sys_wdata;
    end
  end

  // software may reload these to nest safely
  always_ff @(posedge clk) begin
    if (!nrst) begin
      mi_saved_pc_q <= 32'h0000_0000;
      mi_saved_st_q <= 32'h0000_0000;
    end else if (take_mi) begin
      mi_saved_pc_q <= ret_pc;
      mi_saved_st_q <= psw_q;
    end else if (sys_wr && sys_sel == NMIC_SR_MI_PC) begin
      mi_saved_pc_q <= sys_wdata;
    end else if (sys_wr && sys_sel == NMIC_SR_MI_ST) begin
      mi_saved_st_q <= sys_wdata;
    end
  end

  // each half keeps its last code while the other is written
  always_ff @(posedge clk) begin
    if (!nrst) begin
      ecr_q <= 32'h0000_0000;
    end else if (take_nmi) begin
      ecr_q[31:16] <= NMIC_NMI_CODE;
    end else if (take_mi) begin
      ecr_q[15:0] <= mi_code(best_idx);
    end
  end

  // ---------------- in-service levels ----------------
  always_ff @(posedge clk) begin
    if (!nrst) begin
      isr_q <= NMIC_ISR_RESET;
    end else if (take_mi) begin
      isr_q[best_lvl] <= 1'b1;
    end else if (return_from_interrupt_req && !ep && !np && isr_any) begin
      isr_q[isr_top] <= 1'b0;
    end
  end

  // ---------------- pc redirect ----------------
  always_ff @(posedge clk) begin
    if (!nrst) begin
      pc_load_q <= 1'b0;
      pc_addr_q <= 32'h0000_0000;
    end else if (take_nmi) begin
      pc_load_q <= 1'b1;
      pc_addr_q <= NMIC_NMI_VECTOR;
    end else if (take_mi) begin
      pc_load_q <= 1'b1;
      pc_addr_q <= {16'h0000, mi_code(best_idx)};
    end else if (return_from_interrupt_req && !ep) begin
      pc_load_q <= 1'b1;
      pc_addr_q <= np ? nmi_saved_pc_q : mi_saved_pc_q;
    end else begin
      pc_load_q <= 1'b0;
    end
  end
endmodule : nmic_ctrl

// ### design/nmic_pkg.sv
// constants shared by the interrupt controller
// Operation
// - non-maskable request ignores global disable, has no priority, beats all others
// - edge select bit 0: 0 falling, 1 rising raises the non-maskable request
// - new non-maskable request waits pending until its routine returns
// - only one non-maskable request is kept pending at a time
// - non-maskable entry saves pc and status, writes cause 0010h upper half
// - non-maskable entry sets active and block flags, clears trap, jumps 00000010h
// - return with trap 0 and active 1 restores pc and status from nmi copies
// - non-maskable active flag blocks every interrupt and exception acceptance
// - forty-nine maskable sources, each with its own mask
// - eight programmable levels; ties broken by fixed default order
// - maskable acceptance sets the block flag
// - after unmask in a routine only strictly higher levels nest
// - maskable entry saves pc and status, writes source code lower half
// - maskable entry sets block flag, clears trap, jumps to source handler
// - masked or blocked requests stay pending until unmasked or flags clear
// - return with trap 0 and active 0 restores pc and status from maskable copies
// - a source's pending flag clears in hardware when it is accepted
// - acceptance sets level in service; maskable return clears highest set level
// - default order value 0 is highest among same-cycle requests
package nmic_pkg;
  localparam int unsigned        NMIC_NSRC        = 49;
  localparam int unsigned        NMIC_ADDR_W      = 28;
  // byte addresses on the register bus
  localparam logic [27:0]        NMIC_EDGE_ADDR   = 28'hffff880;
  localparam logic [27:0]        NMIC_CTRL_BASE   = 28'hffff100;
  localparam logic [27:0]        NMIC_ISR_ADDR    = 28'hffff1f8;
  localparam logic [7:0]         NMIC_EDGE_RESET  = 8'h00;
  localparam int unsigned        NMIC_EDGE_SEL_B  = 0;
  // per-source control layout
  localparam int unsigned        NMIC_PEND_B      = 7;
  localparam int unsigned        NMIC_MASK_B      = 6;
  localparam logic [7:0]         NMIC_CTRL_RESET  = 8'h47;
  localparam logic [7:0]         NMIC_ISR_RESET   = 8'h00;
  // status word flag positions
  localparam int unsigned        NMIC_PSW_NP_B    = 7;
  localparam int unsigned        NMIC_PSW_EP_B    = 6;
  localparam int unsigned        NMIC_PSW_ID_B    = 5;
  localparam logic [31:0]        NMIC_PSW_RESET   = 32'h0000_0020;
  // cause codes and vectors
  localparam logic [15:0]        NMIC_NMI_CODE    = 16'h0010;
  localparam logic [31:0]        NMIC_NMI_VECTOR  = 32'h0000_0010;
  localparam logic [15:0]        NMIC_MI_CODE_0   = 16'h0080;
  // system register select on the core port
  typedef enum logic [2:0] {
    NMIC_SR_PSW     = 3'b000,
    NMIC_SR_NMI_PC  = 3'b001,
    NMIC_SR_NMI_ST  = 3'b010,
    NMIC_SR_MI_PC   = 3'b011,
    NMIC_SR_MI_ST   = 3'b100
  } nmic_sysreg_t;
endpackage : nmic_pkg

// ### design/nmic_src.sv
// one maskable source: pending flag, mask and priority level
`timescale 1ns/1ns
module nmic_src
  import nmic_pkg::*;
(
  input  wire logic       clk,     // system clock
  input  wire logic       nrst,    // sync reset, active low
  input  wire logic       req,     // request pulse from peripheral
  input  wire logic       ack,     // acceptance of this source
  input  wire logic       wr,      // software write of control byte
  input  wire logic [7:0] wdata,   // control byte written
  output logic            pend_q,  // request pending
  output logic            mask_q,  // source masked
  output logic [2:0]      prio_q   // programmable level
);
  always_ff @(posedge clk) begin
    if (!nrst) begin
      pend_q <= NMIC_CTRL_RESET[NMIC_PEND_B];
    end else if (req) begin
      pend_q <= 1'b1; // set beats clear
    end else if (ack) begin
      pend_q <= 1'b0;
    end else if (wr) begin
      pend_q <= wdata[NMIC_PEND_B];
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      mask_q <= NMIC_CTRL_RESET[NMIC_MASK_B];
      prio_q <= NMIC_CTRL_RESET[2:0];
    end else if (wr) begin
      mask_q <= wdata[NMIC_MASK_B];
      prio_q <= wdata[2:0];
    end
  end
endmodule : nmic_src

// ### tb/nmic_checker.sv
// checker on the controller's entry and return ports
`timescale 1ns/1ns
module nmic_checker (
  input wire logic        clk,            // system clock
  input wire logic        nrst,           // sync reset, active low
  input wire logic [31:0] ret_pc,         // return pc
  input wire logic        return_from_interrupt_req,       // return pulse
  input wire logic        sys_wr,         // register load pulse
  input wire logic [31:0] psw_q,          // status word
  input wire logic [31:0] nmi_saved_pc_q, // nmi pc copy
  input wire logic [31:0] nmi_saved_st_q, // nmi status copy
  input wire logic [31:0] mi_saved_pc_q,  // maskable pc copy
  input wire logic [31:0] mi_saved_st_q,  // maskable status copy
  input wire logic [31:0] ecr_q,          // cause codes
  input wire logic [7:0]  isr_q,          // levels in service
  input wire logic        pc_load_q,      // redirect pulse
  input wire logic [31:0] pc_addr_q       // redirect target
);
  import nmic_pkg::*;
  logic np, ep, id;
  assign np = psw_q[NMIC_PSW_NP_B];
  assign ep = psw_q[NMIC_PSW_EP_B];
  assign id = psw_q[NMIC_PSW_ID_B];
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  property p_nmi_entry;
    pc_load_q && np && !$past(np) |-> pc_addr_q == NMIC_NMI_VECTOR && id && !ep;
  endproperty
  a_nmi_entry: assert property (p_nmi_entry) else $error("nmi entry wrong");
  property p_nmi_save;
    pc_load_q && np && !$past(np) |-> ecr_q[31:16] == NMIC_NMI_CODE
      && nmi_saved_pc_q == $past(ret_pc) && nmi_saved_st_q == $past(psw_q);
  endproperty
  a_nmi_save: assert property (p_nmi_save) else $error("nmi copies wrong");
  property p_np_block;
    np && !return_from_interrupt_req |=> !pc_load_q;
  endproperty
  a_np_block: assert property (p_np_block) else $error("entry while nmi active");
  property p_nmi_ret;
    return_from_interrupt_req && np && !ep |=> pc_load_q && pc_addr_q == $past(nmi_saved_pc_q)
      && psw_q == $past(nmi_saved_st_q);
  endproperty
  a_nmi_ret: assert property (p_nmi_ret) else $error("nmi return wrong");
  property p_mi_ret;
    return_from_interrupt_req && !np && !ep |=> pc_load_q && pc_addr_q == $past(mi_saved_pc_q)
      && psw_q == $past(mi_saved_st_q);
  endproperty
  a_mi_ret: assert property (p_mi_ret) else $error("maskable return wrong");
  property p_isr_ret;
    return_from_interrupt_req && !np && !ep |=> isr_q == ($past(isr_q) & ($past(isr_q) - 8'h01));
  endproperty
  a_isr_ret: assert property (p_isr_ret) else $error("level not released");
  property p_mi_entry;
    pc_load_q && !np && !$past(return_from_interrupt_req) |-> id && !ep && pc_addr_q == {16'h0, ecr_q[15:0]}
      && $countones(isr_q) == $countones($past(isr_q)) + 1;
  endproperty
  a_mi_entry: assert property (p_mi_entry) else $error("maskable entry wrong");
  property p_mi_save;
    pc_load_q && !np && !$past(return_from_interrupt_req) |-> mi_saved_pc_q == $past(ret_pc)
      && mi_saved_st_q == $past(psw_q);
  endproperty
  a_mi_save: assert property (p_mi_save) else $error("maskable copies wrong");
  property p_id_block;
    !np && id && !return_from_interrupt_req && !sys_wr |=> !pc_load_q || np;
  endproperty
  a_id_block: assert property (p_id_block) else $error("entry while blocked");
  c_nmi: cover property (pc_load_q && np && !$past(np));
  c_mi: cover property (pc_load_q && !np && !$past(return_from_interrupt_req));
  c_nest: cover property ($countones(isr_q) == 2);
endmodule : nmic_checker
bind nmic_ctrl nmic_checker u_chk (.clk, .nrst, .ret_pc, .return_from_interrupt_req, .sys_wr, .psw_q,
  .nmi_saved_pc_q, .nmi_saved_st_q, .mi_saved_pc_q, .mi_saved_st_q, .ecr_q, .isr_q,
  .pc_load_q, .pc_addr_q);

// ### tb/nmic_core_model.sv
// core-side model: return pc and one-cycle instruction pulses
`timescale 1ns/1ns
module nmic_core_model (
  input  wire logic              clk,       // system clock
  input  wire logic              nrst,      // sync reset, active low
  input  wire logic [2:0]        cmd,       // 1 ret, 2 unmask, 3 mask, 4 psw, 5/6 mi pc/st, 7 nmi pc
  input  wire logic [31:0]       cmd_data,  // value for a system register load
  input  wire logic [31:0]       pc_seed,   // pc the core would resume at
  output logic      [31:0]       ret_pc,    // return pc offered
  output logic                   return_from_interrupt_req,  // return pulse
  output logic                   ei_req,    // unmask pulse
  output logic                   di_req,    // mask pulse
  output logic                   sys_wr,    // system register load pulse
  output nmic_pkg::nmic_sysreg_t sys_sel,   // register selected
  output logic      [31:0]       sys_wdata  // value loaded
);
  import nmic_pkg::*;
  always_ff @(posedge clk) begin
    if (!nrst) begin
      {return_from_interrupt_req, ei_req, di_req, sys_wr} <= 4'h0;
      sys_sel   <= NMIC_SR_PSW;
      sys_wdata <= 32'h0;
    end else begin
      return_from_interrupt_req <= (cmd == 3'h1);
      ei_req   <= (cmd == 3'h2);
      di_req   <= (cmd == 3'h3);
      sys_wr   <= (cmd >= 3'h4);
      sys_sel  <= (cmd == 3'h5) ? NMIC_SR_MI_PC :
                  (cmd == 3'h6) ? NMIC_SR_MI_ST :
                  (cmd == 3'h7) ? NMIC_SR_NMI_PC : NMIC_SR_PSW;
      // data is junk outside a load so a stale value is never trusted
      sys_wdata <= (cmd >= 3'h4) ? cmd_data : ~sys_wdata;
    end
    ret_pc <= pc_seed;
  end
endmodule : nmic_core_model

// ### tb/testbench.sv
// self-checking bench for the interrupt controller
`timescale 1ns/1ns
module testbench;
  import nmic_pkg::*;
  logic         clk = 0, nrst = 0, avs_read = 0, avs_write = 0, nmi_pin = 0;
  logic         avs_waitrequest, pc_load_q, return_from_interrupt_req, ei_req, di_req, sys_wr;
  logic [27:0]  avs_address = '0;
  logic [31:0]  avs_writedata = '0, cmd_data = '0, pc_seed = '0, avs_readdata, ret_pc;
  logic [31:0]  sys_wdata, psw_q, nmi_saved_pc_q, nmi_saved_st_q, mi_saved_pc_q;
  logic [31:0]  mi_saved_st_q, ecr_q, pc_addr_q, rd, r;
  logic [48:0]  irq_req = '0;
  logic [7:0]   isr_q;
  logic [2:0]   cmd = '0;
  nmic_sysreg_t sys_sel;
  int           failures = 0, checked = 0, i, j, k, lv;
  always #10 clk = ~clk;
  nmic_ctrl u_dut (.clk, .nrst, .avs_address, .avs_read, .avs_write, .avs_writedata,
    .avs_readdata, .avs_waitrequest, .nmi_pin, .irq_req, .ret_pc, .return_from_interrupt_req, .ei_req,
    .di_req, .sys_wr, .sys_sel, .sys_wdata, .psw_q, .nmi_saved_pc_q, .nmi_saved_st_q,
    .mi_saved_pc_q, .mi_saved_st_q, .ecr_q, .isr_q, .pc_load_q, .pc_addr_q);
  nmic_core_model u_core (.clk, .nrst, .cmd, .cmd_data, .pc_seed, .ret_pc, .return_from_interrupt_req,
    .ei_req, .di_req, .sys_wr, .sys_sel, .sys_wdata);
  function automatic logic [27:0] ca(input int n);
    return NMIC_CTRL_BASE + 28'(4 * n);
  endfunction : ca
  function automatic logic [31:0] mv(input int n);
    return 32'h80 + 32'(16 * n);
  endfunction : mv
  task automatic close_out;
    if (failures == 0 && checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : close_out
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    checked++;
    if (s !== e) begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  task automatic cut(input int n);
    if (n >= 40) begin
      failures++;
      close_out();
    end
  endtask : cut
  task automatic bus(input logic w, input logic [27:0] a, input logic [7:0] d);
    int n;
    n = 0;
    avs_address <= a;
    avs_write <= w;
    avs_read <= !w;
    avs_writedata <= {24'h0, d};
    do begin
      @(posedge clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 40);
    rd = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    cut(n);
    @(posedge clk);
  endtask : bus
  task automatic rdc(input logic [27:0] a, input logic [31:0] e);
    bus(1'b0, a, 8'h0);
    chk("readdata", rd, e);
  endtask : rdc
  task automatic core(input logic [2:0] c, input logic [31:0] d);
    cmd <= c;
    cmd_data <= d;
    @(posedge clk);
    cmd <= 3'h0;
    @(posedge clk);
  endtask : core
  // waits for a redirect, then checks its target and status word
  task automatic wl(input logic [31:0] a, input logic [31:0] p);
    int n;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pc_load_q !== 1'b1 && n < 40);
    cut(n);
    chk("pc_addr", pc_addr_q, a);
    chk("psw", psw_q, p);
  endtask : wl
  task automatic quiet(input int n);
    repeat (n) begin
      @(posedge clk);
      chk("no_load", pc_load_q, 32'h0);
    end
  endtask : quiet
  initial begin
    i = $urandom(32'h3ff25166);
    repeat (4) @(posedge clk);
    nrst <= 1'b1;
    rdc(NMIC_EDGE_ADDR, 32'h0);
    rdc(ca(0), 32'h47);
    rdc(NMIC_ISR_ADDR, 32'h0);
    bus(1'b1, 28'hffff8c0, 8'hff);
    rdc(28'hffff8c0, 32'h0);
    chk("psw", psw_q, 32'h20);
    r = $urandom & 32'hffff_fffc;
    pc_seed <= r;
    bus(1'b1, NMIC_EDGE_ADDR, 8'h01);
    rdc(NMIC_EDGE_ADDR, 32'h1);
    // rising edge taken although maskable entry is disabled
    nmi_pin <= 1'b1;
    wl(32'h10, 32'ha0);
    chk("ecr_hi", ecr_q[31:16], 32'h10);
    chk("nmi_pc", nmi_saved_pc_q, r);
    chk("nmi_st", nmi_saved_st_q, 32'h20);
    repeat (2) begin
      nmi_pin <= 1'b0;
      quiet(4);
      nmi_pin <= 1'b1;
      quiet(4);
    end
    core(3'h1, 0);
    wl(r, 32'h20);
    wl(32'h10, 32'ha0);
    core(3'h1, 0);
    wl(r, 32'h20);
    quiet(8);
    bus(1'b1, NMIC_EDGE_ADDR, 8'h00);
    nmi_pin <= 1'b0;
    wl(32'h10, 32'ha0);
    // handler rewrites its own return address before returning
    core(3'h7, r ^ 32'h0000_0200);
    core(3'h1, 0);
    wl(r ^ 32'h0000_0200, 32'h20);
    nmi_pin <= 1'b1;
    quiet(8);
    i = $urandom_range(47, 1);
    j = $urandom_range(48, i + 1);
    k = i - 1;
    lv = $urandom_range(7, 1);
    bus(1'b1, ca(i), 8'(lv));
    bus(1'b1, ca(j), 8'(lv));
    irq_req <= (49'h1 << i) | (49'h1 << j) | (49'h1 << k);
    @(posedge clk);
    irq_req <= '0;
    quiet(4);
    rdc(ca(i), 32'h80 | lv);
    core(3'h4, 0);
    wl(mv(i), 32'h20);
    chk("ecr_lo", ecr_q[15:0], mv(i));
    chk("mi_pc", mi_saved_pc_q, r);
    chk("mi_st", mi_saved_st_q, 32'h0);
    chk("isr", isr_q, 32'h1 << lv);
    rdc(ca(i), lv);
    // nested entry sees another return pc than the outer one
    pc_seed <= r ^ 32'h0000_0100;
    core(3'h2, 0);
    quiet(6);
    // pending bit written as one so the unmask keeps the request
    bus(1'b1, ca(k), 8'(8'h80 | (lv - 1)));
    wl(mv(k), 32'h20);
    chk("isr", isr_q, (32'h1 << lv) | (32'h1 << (lv - 1)));
    chk("mi_pc", mi_saved_pc_q, r ^ 32'h0000_0100);
    core(3'h1, 0);
    wl(r ^ 32'h0000_0100, 32'h0);
    chk("isr", isr_q, 32'h1 << lv);
    quiet(6);
    core(3'h3, 0);
    // software puts back the outer copies it kept before unmasking
    core(3'h5, r);
    core(3'h6, 0);
    core(3'h1, 0);
    wl(r, 32'h0);
    wl(mv(j), 32'h20);
    chk("isr", isr_q, 32'h1 << lv);
    close_out();
  end
endmodule : testbench
